/* File: shared/osd_pkg.sv */
// Package of offsets, fields, codes and counts for the oscillator select and CPU slowdown block
package osd_pkg;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [31:0] OFF_OSC_REQUEST = 32'h0000_0000;
    localparam logic [31:0] OFF_OSC_CURRENT = 32'h0000_0004;
    localparam logic [31:0] OFF_SW_STATUS   = 32'h0000_0008;
    localparam logic [31:0] OFF_SLOWDOWN    = 32'h0000_000C;
    localparam logic [31:0] OFF_IRQ_STATUS  = 32'h0000_0010;
    localparam logic [31:0] OFF_IRQ_MASK    = 32'h0000_0014;
    localparam logic [31:0] OFF_OSC_CONFIG  = 32'h0030_0000;

    // Oscillator configuration byte fields
    localparam int          CFG_RESET_OSC_SELECT_LSB  = 4;
    localparam int          CFG_EXTMODE_LSB = 0;
    localparam logic [7:0]  CFG_UNIMP_ONES  = 8'h88;

    // Oscillator selection codes
    localparam logic [2:0]  OSC_EXT         = 3'h7;
    localparam logic [2:0]  OSC_FAST_4M     = 3'h6;
    localparam logic [2:0]  OSC_SLOW        = 3'h5;
    localparam logic [2:0]  OSC_SECONDARY   = 3'h4;
    localparam logic [2:0]  OSC_EXT_PLL     = 3'h2;
    localparam logic [2:0]  OSC_FAST_64M    = 3'h0;
    localparam logic [2:0]  OSC_RESET_ALT   = 3'h6;

    // External oscillator mode codes
    localparam logic [2:0]  EXT_EC_HIGH     = 3'h7;
    localparam logic [2:0]  EXT_EC_MED      = 3'h6;
    localparam logic [2:0]  EXT_EC_LOW      = 3'h5;
    localparam logic [2:0]  EXT_OFF         = 3'h4;
    localparam logic [2:0]  EXT_HS_XTAL     = 3'h2;
    localparam logic [2:0]  EXT_XT_XTAL     = 3'h1;
    localparam logic [2:0]  EXT_LP_XTAL     = 3'h0;

    // Drive power levels
    localparam logic [1:0]  PWR_LVL_LOW     = 2'h0;
    localparam logic [1:0]  PWR_LVL_MED     = 2'h1;
    localparam logic [1:0]  PWR_LVL_HIGH    = 2'h2;

    // Clock switch status fields
    localparam int          SW_HOLD_BIT     = 7;
    localparam int          SW_SECPWR_BIT   = 6;
    localparam int          SW_SWITCHED_BIT = 4;
    localparam int          SW_NEWRDY_BIT   = 3;

    // CPU slowdown control fields
    localparam int          SD_IDLE_BIT     = 7;
    localparam int          SD_DOZE_EN_BIT  = 6;
    localparam int          SD_ROI_BIT      = 5;
    localparam int          SD_DOR_BIT      = 4;
    localparam int          SD_RATIO_LSB    = 0;
    localparam logic [7:0]  SD_RESET        = 8'h00;

    // Interrupt status and mask fields
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_SWITCH_DONE = 0;
    localparam int          IRQ_NEW_READY   = 1;

    // Timing: one instruction cycle is four system clocks
    localparam int          SYS_CLK_MHZ     = 100;
    localparam logic [3:0]  INSTR_LOG2      = 4'h2;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Power state of the clock tree
    typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_SLEEP} osd_pwr_t;

endpackage

/* File: design/osd_pulse_div.sv */
// Power-of-two enable divider producing a one-cycle pulse per wrap
`timescale 1ns/100ps
`default_nettype none

module osd_pulse_div (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tick_in,
    input  wire logic       clr,
    input  wire logic [3:0] log2_ratio,
    output logic            pulse
);

    typedef struct packed {
        logic [7:0] count;
    } osd_div_state_t;

    osd_div_state_t s;
    osd_div_state_t s_next;
    logic [7:0]     wrap_at;

    // Terminal count and wrap pulse
    always_comb begin
        wrap_at = 8'((16'h0001 << log2_ratio) - 16'h0001);
        pulse   = tick_in && !clr && (s.count == wrap_at);
        s_next  = s;
        if (!aresetn || clr) begin
            s_next.count = 8'h00;
        end else if (tick_in) begin
            s_next.count = (s.count == wrap_at) ? 8'h00 : s.count + 8'h01;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        s <= s_next;
    end

endmodule

`default_nettype wire

/* File: design/osd_top.sv */
// Oscillator selection, clock switch status and CPU slowdown control with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

module osd_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  nv_config,
    input  wire logic [7:0]  osc_ready_async,
    input  wire logic        irq_entry,
    input  wire logic        irq_return_instr,
    input  wire logic        in_circuit_debugger,
    input  wire logic        sleep_exec,
    input  wire logic        wake_event,
    output logic [2:0]       current_osc_select,
    output logic [2:0]       ext_osc_mode,
    output logic             ext_osc_enable,
    output logic             crystal_drive_enable,
    output logic [1:0]       drive_power_level,
    output logic             pll_enable,
    output logic             fast_osc_freq_select,
    output logic             clock_divider,
    output logic             secondary_power_level,
    output logic             cpu_instr_en,
    output logic             periph_instr_en,
    output logic             cpu_clk_run,
    output logic             periph_clk_run,
    output logic             irq
);

    typedef struct packed {
        logic [7:0]             cfg;
        logic [2:0]             cur;
        logic [2:0]             req;
        logic                   fast64;
        logic                   div4;
        logic                   hold;
        logic                   sec_pwr;
        logic                   new_rdy;
        logic [7:0]             rdy_s1;
        logic [7:0]             rdy_s2;
        logic                   idle;
        logic                   doze_en;
        logic                   recover_on_irq;
        logic                   dor;
        logic [2:0]             ratio;
        osd_pkg::osd_pwr_t      pwr;
        logic [1:0]             irq_status;
        logic [1:0]             irq_mask;
        logic                   aw_got;
        logic [31:0]            awaddr;
        logic                   w_got;
        logic [7:0]             wdata;
        logic                   wstrb0;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic                   ext_en;
        logic                   xtal;
        logic [1:0]             pwr_lvl;
        logic                   pll_en;
        logic                   cpu_en;
        logic                   periph_en;
        logic                   cpu_run;
        logic                   periph_run;
        logic                   irq;
    } osd_top_state_t;

    osd_top_state_t s;
    osd_top_state_t s_next;
    logic           instr_tick;
    logic           doze_tick;
    logic           doze_active;
    logic [3:0]     doze_log2;

    // Debug overrides the slowdown without altering the stored enable
    assign doze_active = s.doze_en && !in_circuit_debugger;
    assign doze_log2   = {1'b0, s.ratio} + 4'h1;

    // Peripheral instruction cycle: one pulse every four system clocks
    osd_pulse_div u_instr_div (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .tick_in    (1'b1),
        .clr        (1'b0),
        .log2_ratio (osd_pkg::INSTR_LOG2),
        .pulse      (instr_tick)
    );

    // CPU instruction cycle while slowed: one per 2^(ratio+1) peripheral cycles
    osd_pulse_div u_doze_div (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .tick_in    (instr_tick),
        .clr        (!doze_active),
        .log2_ratio (doze_log2),
        .pulse      (doze_tick)
    );

    // Register read mux: {hit, data}
    function automatic logic [32:0] read_word(input osd_top_state_t st, input logic [31:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case (a)
            osd_pkg::OFF_OSC_CONFIG:  r[7:0] = st.cfg | osd_pkg::CFG_UNIMP_ONES;
            osd_pkg::OFF_OSC_REQUEST: r[2:0] = st.req;
            osd_pkg::OFF_OSC_CURRENT: r[2:0] = st.cur;
            osd_pkg::OFF_SW_STATUS: begin
                r[osd_pkg::SW_HOLD_BIT]     = st.hold;
                r[osd_pkg::SW_SECPWR_BIT]   = st.sec_pwr;
                r[osd_pkg::SW_SWITCHED_BIT] = (st.cur == st.req);
                r[osd_pkg::SW_NEWRDY_BIT]   = st.new_rdy;
            end
            osd_pkg::OFF_SLOWDOWN: begin
                r[osd_pkg::SD_IDLE_BIT]               = st.idle;
                r[osd_pkg::SD_DOZE_EN_BIT]            = st.doze_en;
                r[osd_pkg::SD_ROI_BIT]                = st.recover_on_irq;
                r[osd_pkg::SD_DOR_BIT]                = st.dor;
                r[osd_pkg::SD_RATIO_LSB +: 3]         = st.ratio;
            end
            osd_pkg::OFF_IRQ_STATUS:  r[1:0] = st.irq_status;
            osd_pkg::OFF_IRQ_MASK:    r[1:0] = st.irq_mask;
            default:                  r      = {1'b0, 32'h0000_0000};
        endcase
        return r;
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic [2:0]  rst_code;
        logic [2:0]  mode;
        logic [32:0] rd;
        logic        pending;
        logic        switch_go;
        rst_code  = nv_config[osd_pkg::CFG_RESET_OSC_SELECT_LSB +: 3];
        mode      = 3'h0;
        rd        = 33'h0_0000_0000;
        pending   = (s.req != s.cur);
        switch_go = 1'b0;
        s_next    = s;

        // Oscillator ready pins pass two flip-flops
        s_next.rdy_s1 = osc_ready_async;
        s_next.rdy_s2 = s.rdy_s1;

        // Bus write channel capture
        if (s_axi_awvalid && s.awready) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            s_next.w_got  = 1'b1;
            s_next.wdata  = s_axi_wdata[7:0];
            s_next.wstrb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Register write once address and data are both held
        if (s.aw_got && s.w_got && !s.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            rd            = read_word(s, s.awaddr);
            s_next.bresp  = rd[32] ? osd_pkg::RESP_OKAY : osd_pkg::RESP_SLVERR;
            if (s.wstrb0) begin
                case (s.awaddr)
                    osd_pkg::OFF_OSC_REQUEST: s_next.req = s.wdata[2:0];
                    osd_pkg::OFF_SW_STATUS: begin
                        s_next.hold    = s.wdata[osd_pkg::SW_HOLD_BIT];
                        s_next.sec_pwr = s.wdata[osd_pkg::SW_SECPWR_BIT];
                    end
                    osd_pkg::OFF_SLOWDOWN: begin
                        s_next.idle    = s.wdata[osd_pkg::SD_IDLE_BIT];
                        s_next.doze_en = s.wdata[osd_pkg::SD_DOZE_EN_BIT];
                        s_next.recover_on_irq     = s.wdata[osd_pkg::SD_ROI_BIT];
                        s_next.dor     = s.wdata[osd_pkg::SD_DOR_BIT];
                        s_next.ratio   = s.wdata[osd_pkg::SD_RATIO_LSB +: 3];
                    end
                    osd_pkg::OFF_IRQ_STATUS: s_next.irq_status = s.irq_status & ~s.wdata[1:0];
                    osd_pkg::OFF_IRQ_MASK:   s_next.irq_mask   = s.wdata[1:0];
                    default: ;
                endcase
            end
        end

        // Bus read: one outstanding, data captured at address acceptance
        if (s.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            rd            = read_word(s, s_axi_araddr);
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd[31:0];
            s_next.rresp  = rd[32] ? osd_pkg::RESP_OKAY : osd_pkg::RESP_SLVERR;
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready  = !s_next.w_got && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;

        // Clock switch: flag follows the new oscillator, switch lands next instruction cycle
        s_next.new_rdy = pending && s.rdy_s2[s.req];
        switch_go      = pending && s.new_rdy && !s.hold && instr_tick;
        if (switch_go) begin
            s_next.cur     = s.req;
            s_next.new_rdy = 1'b0;
            s_next.irq_status[osd_pkg::IRQ_SWITCH_DONE] = 1'b1;
        end
        if (s_next.new_rdy && !s.new_rdy) begin
            s_next.irq_status[osd_pkg::IRQ_NEW_READY] = 1'b1;
        end

        // Interrupt entry and return steer the slowdown enable
        if (irq_entry && s.recover_on_irq) begin
            s_next.doze_en = 1'b0;
        end else if (irq_return_instr && s.dor) begin
            s_next.doze_en = 1'b1;
        end

        // Sleep and idle states of the clock tree
        unique case (s.pwr)
            osd_pkg::PWR_RUN: begin
                if (sleep_exec) begin
                    s_next.pwr = s.idle ? osd_pkg::PWR_IDLE : osd_pkg::PWR_SLEEP;
                end
            end
            osd_pkg::PWR_IDLE, osd_pkg::PWR_SLEEP: begin
                if (wake_event) begin
                    s_next.pwr = osd_pkg::PWR_RUN;
                end
            end
            default: s_next.pwr = osd_pkg::PWR_RUN;
        endcase
        s_next.cpu_run    = (s_next.pwr == osd_pkg::PWR_RUN);
        s_next.periph_run = (s_next.pwr != osd_pkg::PWR_SLEEP);

        // Synchronous reset loads the selection from the config byte
        if (!aresetn) begin
            s_next            = '0;
            s_next.cfg        = nv_config;
            s_next.cur        = (rst_code == osd_pkg::OSC_FAST_64M) ? osd_pkg::OSC_RESET_ALT
                                                                     : rst_code;
            s_next.req        = s_next.cur;
            s_next.fast64     = (rst_code == osd_pkg::OSC_FAST_64M);
            s_next.div4       = (rst_code != osd_pkg::OSC_FAST_64M);
            s_next.pwr        = osd_pkg::PWR_RUN;
            s_next.cpu_run    = 1'b1;
            s_next.periph_run = 1'b1;
            s_next.awready    = 1'b1;
            s_next.wready     = 1'b1;
            s_next.arready    = 1'b1;
            {s_next.idle, s_next.doze_en, s_next.recover_on_irq, s_next.dor} = osd_pkg::SD_RESET[7:4];
            s_next.ratio      = osd_pkg::SD_RESET[2:0];
        end

        // External oscillator decode, used while an external source is selected or requested
        mode          = s_next.cfg[osd_pkg::CFG_EXTMODE_LSB +: 3];
        s_next.pll_en = (s_next.cur == osd_pkg::OSC_EXT_PLL);
        s_next.ext_en = (s_next.cur == osd_pkg::OSC_EXT) || s_next.pll_en
                        || (s_next.req == osd_pkg::OSC_EXT) || (s_next.req == osd_pkg::OSC_EXT_PLL);
        s_next.xtal   = 1'b0;
        s_next.pwr_lvl = osd_pkg::PWR_LVL_LOW;
        unique case (mode)
            osd_pkg::EXT_EC_HIGH: s_next.pwr_lvl = osd_pkg::PWR_LVL_HIGH;
            osd_pkg::EXT_EC_MED:  s_next.pwr_lvl = osd_pkg::PWR_LVL_MED;
            osd_pkg::EXT_EC_LOW:  s_next.pwr_lvl = osd_pkg::PWR_LVL_LOW;
            osd_pkg::EXT_HS_XTAL: begin
                s_next.xtal    = 1'b1;
                s_next.pwr_lvl = osd_pkg::PWR_LVL_HIGH;
            end
            osd_pkg::EXT_XT_XTAL: begin
                s_next.xtal    = 1'b1;
                s_next.pwr_lvl = osd_pkg::PWR_LVL_MED;
            end
            osd_pkg::EXT_LP_XTAL: begin
                s_next.xtal    = 1'b1;
                s_next.pwr_lvl = osd_pkg::PWR_LVL_LOW;
            end
            default: s_next.ext_en = 1'b0;
        endcase
        s_next.xtal = s_next.xtal && s_next.ext_en;

        // Instruction enables and the interrupt line
        s_next.periph_en = aresetn && s_next.periph_run && instr_tick;
        s_next.cpu_en    = aresetn && s_next.cpu_run
                           && (doze_active ? doze_tick : instr_tick);
        s_next.irq       = |(s_next.irq_status & s_next.irq_mask);
    end

    // State register
    always_ff @(posedge aclk) begin
        s <= s_next;
    end

    // Outputs straight from the state register
    assign s_axi_awready         = s.awready;
    assign s_axi_wready          = s.wready;
    assign s_axi_bvalid          = s.bvalid;
    assign s_axi_bresp           = s.bresp;
    assign s_axi_arready         = s.arready;
    assign s_axi_rvalid          = s.rvalid;
    assign s_axi_rdata           = s.rdata;
    assign s_axi_rresp           = s.rresp;
    assign current_osc_select    = s.cur;
    assign ext_osc_mode          = s.cfg[osd_pkg::CFG_EXTMODE_LSB +: 3];
    assign ext_osc_enable        = s.ext_en;
    assign crystal_drive_enable  = s.xtal;
    assign drive_power_level     = s.pwr_lvl;
    assign pll_enable            = s.pll_en;
    assign fast_osc_freq_select  = s.fast64;
    assign clock_divider         = s.div4;
    assign secondary_power_level = s.sec_pwr;
    assign cpu_instr_en          = s.cpu_en;
    assign periph_instr_en       = s.periph_en;
    assign cpu_clk_run           = s.cpu_run;
    assign periph_clk_run        = s.periph_run;
    assign irq                   = s.irq;

endmodule

`default_nettype wire

/* File: sim/osd_props.sv */
// Port timing checker for the oscillator select and CPU slowdown block
`timescale 1ns/100ps
`default_nettype none
module osd_props (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic [7:0] nv_config,
    input wire logic       in_circuit_debugger,
    input wire logic       sleep_exec,
    input wire logic       wake_event,
    input wire logic [2:0] current_osc_select,
    input wire logic [2:0] ext_osc_mode,
    input wire logic       ext_osc_enable,
    input wire logic       crystal_drive_enable,
    input wire logic       cpu_instr_en,
    input wire logic       periph_instr_en,
    input wire logic       cpu_clk_run,
    input wire logic       periph_clk_run
);
    // Every check on the rising edge, quiet while reset is held
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_load: assert property (
        $rose(aresetn) |-> current_osc_select == (nv_config[6:4] == 3'h0 ? 3'h6 : nv_config[6:4]))
        else $error("selection not loaded at reset");
    a_ext_off: assert property (
        ext_osc_mode == 3'h4 |-> !ext_osc_enable) else $error("external on in off mode");
    a_xtal_mode: assert property (
        crystal_drive_enable |-> ext_osc_enable && ext_osc_mode <= 3'h2) else $error("bad crystal");
    a_periph_gap: assert property (
        periph_instr_en |=> !periph_instr_en [*3]) else $error("peripheral cycle too short");
    a_cpu_on_tick: assert property (
        cpu_instr_en |-> periph_instr_en) else $error("cpu cycle off peripheral cycle");
    a_debug_speed: assert property (
        in_circuit_debugger && $past(in_circuit_debugger) && $past(in_circuit_debugger, 2)
        && cpu_clk_run && periph_instr_en |-> cpu_instr_en) else $error("debug not full speed");
    a_sleep_stop: assert property (
        sleep_exec && cpu_clk_run && periph_clk_run |-> ##[1:2] !cpu_clk_run)
        else $error("cpu clock kept in sleep");
    a_wake_run: assert property (
        wake_event && !sleep_exec |-> ##[1:2] cpu_clk_run && periph_clk_run)
        else $error("clocks not back on wake");
endmodule
bind osd_top osd_props u_props (.*);
`default_nettype wire

/* File: sim/osd_osc_model.sv */
// Far-side sources: internal ones ready at once, external ones after start-up
`timescale 1ns/100ps
`default_nettype none
module osd_osc_model #(parameter int STARTUP = 6) (
    input  wire logic       aclk,
    input  wire logic       ext_en,
    input  wire logic [7:0] stall,
    output logic      [7:0] ready
);
    int cnt = 0;
    // Start-up count runs only while the external source is enabled
    always @(posedge aclk) cnt <= !ext_en ? 0 : (cnt < STARTUP) ? cnt + 1 : cnt;
    // Ready per selection code; the bench can hold any source not ready
    assign ready = ~stall & {cnt == STARTUP, 4'hF, cnt == STARTUP, 2'h3};
endmodule
`default_nettype wire

/* File: sim/tb_osd_top.sv */
// Self-checking bench for the oscillator select and CPU slowdown block
`timescale 1ns/100ps
`default_nettype none
module tb_osd_top;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        irq_entry = 1'b0, irq_return_instr = 1'b0, in_circuit_debugger = 1'b0;
    logic        sleep_exec = 1'b0, wake_event = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_osc_enable, crystal_drive_enable;
    logic        pll_enable, fast_osc_freq_select, clock_divider, secondary_power_level, irq;
    logic        cpu_instr_en, periph_instr_en, cpu_clk_run, periph_clk_run;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [7:0]  nv_config = 8'h67, stall = 8'h00, osc_ready_async;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  current_osc_select, ext_osc_mode, c;
    logic [1:0]  s_axi_bresp, s_axi_rresp, drive_power_level, rsp;
    int          mismatches = 0, checks_done = 0, n;
    // Clock, design and far-side oscillators
    always #5 aclk = ~aclk;
    osd_top dut (.*);
    osd_osc_model u_osc (.aclk(aclk), .ext_en(ext_osc_enable), .stall(stall), .ready(osc_ready_async));
    task automatic print_verdict;
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", s, e, g);
            mismatches++;
        end
    endtask
    // Bus cycles: each channel held until its own handshake
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input string s, input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rsp = s_axi_rresp;
        chk(s, {24'h0, e}, s_axi_rdata & {24'h0, m});
    endtask
    task automatic do_reset(input logic [7:0] v);
        @(posedge aclk);
        aresetn <= 1'b0;
        nv_config <= v;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // Every reset and mode code through the config byte
    task automatic t_cfg;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            do_reset({1'b0, c, 1'b0, c});
            chk("cur", (c == 3'h0) ? 3'h6 : c, current_osc_select);
            rd("req", osd_pkg::OFF_OSC_REQUEST, 8'h07, (c == 3'h0) ? 3'h6 : c);
            rd("cfg", osd_pkg::OFF_OSC_CONFIG, 8'hFF, {1'b1, c, 1'b1, c});
            rd("stat", osd_pkg::OFF_SW_STATUS, 8'h18, 8'h10);
            chk("pll", c == 3'h2, pll_enable);
            chk("fsel", c == 3'h0, fast_osc_freq_select);
            chk("exten", c == 3'h7 || c == 3'h2, ext_osc_enable);
            chk("xtal", c == 3'h2, crystal_drive_enable);
            chk("clock_divider", c != 3'h0, clock_divider);
            chk("mode", c, ext_osc_mode);
            if (c != 3'h4 && c != 3'h3)
                chk("pwr", (c > 3'h4) ? c - 3'h5 : c, drive_power_level);
        end
    endtask
    // Held switch, released switch, interrupt mask and clear, unmapped read
    task automatic t_switch;
        do_reset(8'h67);
        stall <= 8'h20;
        wr(osd_pkg::OFF_SW_STATUS, 8'h80);
        wr(osd_pkg::OFF_OSC_REQUEST, 8'h05);
        repeat (12) @(posedge aclk);
        rd("pend", osd_pkg::OFF_SW_STATUS, 8'h98, 8'h80);
        stall <= 8'h00;
        repeat (12) @(posedge aclk);
        rd("hold", osd_pkg::OFF_SW_STATUS, 8'h98, 8'h88);
        chk("held", 3'h6, current_osc_select);
        rd("irqa", osd_pkg::OFF_IRQ_STATUS, 8'h03, 8'h02);
        wr(osd_pkg::OFF_SW_STATUS, 8'h00);
        repeat (12) @(posedge aclk);
        chk("sw", 3'h5, current_osc_select);
        rd("done", osd_pkg::OFF_SW_STATUS, 8'h18, 8'h10);
        wr(osd_pkg::OFF_SW_STATUS, 8'h40);
        chk("spwr", 1'b1, secondary_power_level);
        chk("irq0", 1'b0, irq);
        wr(osd_pkg::OFF_IRQ_MASK, 8'h01);
        repeat (2) @(posedge aclk);
        chk("irq1", 1'b1, irq);
        wr(osd_pkg::OFF_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge aclk);
        chk("irq2", 1'b0, irq);
        rd("irqb", osd_pkg::OFF_IRQ_STATUS, 8'h03, 8'h02);
        rd("unm", 32'h0000_0040, 8'hFF, 8'h00);
        chk("slverr", osd_pkg::RESP_SLVERR, rsp);
    endtask
    // Peripheral cycles between two cpu cycles
    task automatic gap;
        n = 0;
        do @(posedge aclk); while (cpu_instr_en !== 1'b1);
        do begin
            @(posedge aclk);
            n += periph_instr_en;
        end while (cpu_instr_en !== 1'b1);
    endtask
    // Every ratio code, debug override, hardware updates on entry and return
    task automatic t_doze;
        for (int r = 0; r < 8; r++) begin
            wr(osd_pkg::OFF_SLOWDOWN, 8'h40 | r[7:0]);
            gap;
            gap;
            chk("ratio", 1 << (r + 1), n);
        end
        in_circuit_debugger <= 1'b1;
        gap;
        gap;
        chk("dbg", 1, n);
        rd("cpu_slowdown_enable", osd_pkg::OFF_SLOWDOWN, 8'hFF, 8'h47);
        in_circuit_debugger <= 1'b0;
        wr(osd_pkg::OFF_SLOWDOWN, 8'h67);
        irq_entry <= 1'b1;
        @(posedge aclk);
        irq_entry <= 1'b0;
        rd("roi", osd_pkg::OFF_SLOWDOWN, 8'hFF, 8'h27);
        wr(osd_pkg::OFF_SLOWDOWN, 8'h17);
        irq_return_instr <= 1'b1;
        @(posedge aclk);
        irq_return_instr <= 1'b0;
        rd("doe", osd_pkg::OFF_SLOWDOWN, 8'hFF, 8'h57);
    endtask
    // Sleep with and without idle, then wake
    task automatic t_sleep;
        for (int i = 0; i < 2; i++) begin
            wr(osd_pkg::OFF_SLOWDOWN, (i == 0) ? 8'h80 : 8'h00);
            sleep_exec <= 1'b1;
            @(posedge aclk);
            sleep_exec <= 1'b0;
            repeat (2) @(posedge aclk);
            chk("cpurun", 1'b0, cpu_clk_run);
            chk("perrun", i == 0, periph_clk_run);
            wake_event <= 1'b1;
            @(posedge aclk);
            wake_event <= 1'b0;
            @(posedge aclk);
            chk("wake", 2'h3, {cpu_clk_run, periph_clk_run});
        end
    endtask
    // Main sequence and watchdog
    initial begin
        t_cfg;
        t_switch;
        t_doze;
        t_sleep;
        print_verdict;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        print_verdict;
    end
endmodule
`default_nettype wire
